// file: tcoc_defines.svh
// Register indices, field positions, reset values and counts of the timer core.
// Assumes inclusion by bare name; definitions only.
`ifndef TCOC_DEFINES_SVH
`define TCOC_DEFINES_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define TCOC_IDX_SELECT   6'h00
`define TCOC_IDX_FORCE    6'h01
`define TCOC_IDX_MASK7    6'h02
`define TCOC_IDX_DATA7    6'h03
`define TCOC_IDX_CNTH     6'h04
`define TCOC_IDX_CNTL     6'h05
`define TCOC_IDX_SCR1     6'h06
`define TCOC_IDX_TOV      6'h07
`define TCOC_IDX_ACTH     6'h08
`define TCOC_IDX_ACTL     6'h09
`define TCOC_IDX_FLG1     6'h0E
`define TCOC_IDX_FLG2     6'h0F
`define TCOC_IDX_TC_FIRST 6'h10
`define TCOC_IDX_TC_LAST  6'h1F
`define TCOC_IDX_PULSE_ACCUM_FLAG_REG    6'h21
`define TCOC_IDX_PACH     6'h22
`define TCOC_IDX_PACL     6'h23

// ----------------------------------------
// Fields and values
// ----------------------------------------
`define TCOC_BIT_TEN      7
`define TCOC_BIT_SWAI     6
`define TCOC_BIT_SFRZ     5
`define TCOC_BIT_FFCA     4
`define TCOC_BIT_TOF      7
`define TCOC_BIT_PULSE_ACCUM_OVERFLOW_FLAG    1
`define TCOC_BIT_PULSE_ACCUM_EDGE_FLAG     0
`define TCOC_RST_BYTE     8'h00
`define TCOC_RST_WORD     16'h0000
`define TCOC_CNT_MAX      16'hFFFF
`define TCOC_PA_DIV_LAST  6'h3F
`define TCOC_RESP_OKAY    2'h0
`define TCOC_RESP_SLVERR  2'h2

`endif

// file: tcoc_pkg.sv
// Types shared by the timer core.
// Assumes tcoc_defines.svh supplies the numeric constants.
package tcoc_pkg;

  typedef struct packed {
    logic enable;
    logic stopInWait;
    logic stopInFreeze;
    logic fastFlagClear;
  } tcoc_ctrl_type;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } tcoc_wrstate_type;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } tcoc_action_type;

endpackage

// file: tcoc_port_model.sv
// Timer port pins as the board sees them: a driven level or the pull-down.
// Assumes the pin output and output-enable vectors of the timer core.
module tcoc_port_model (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  output logic [7:0] pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Pin resolution
  // ------
  // Released pins fall to the pull-down rather than keep the last level
  assign pinLevel = pinOut & pinOe;
endmodule

// file: tcoc_timer.sv
// Eight-channel 16-bit timer core: counter, compare actions, stop controls,
// fast flag clearing and an AXI4-Lite register slave.
// Assumes one bus clock, synchronous active-low reset, mode inputs synchronous.
//
// Operation
// - Channel 7 compare copies masked data bits onto the port pins.
// - Main counter is sixteen bits and counts upward.
// - Counter writes are ignored unless test mode is active.
// - First period after a counter write may be short or long.
// - Enable bit low stops prescaler, counter and accumulator clock.
// - No divide-by-64 accumulator clock while the timer is inactive.
// - Stop-in-wait halts timer and accumulator clock in wait mode.
// - Stop-in-freeze halts the counter only while frozen.
// - Fast clear: capture read or compare write clears channel flag.
// - Fast clear: any counter byte access clears overflow flag.
// - Fast clear: accumulator count access clears both accumulator flags.
// - Toggle-on-overflow toggles compare pins on counter overflow.
// - Overflow toggle beats forced compare, yields to channel 7.
// - Mode/level pair: none, toggle, clear, set.
// - Nonzero mode/level pair makes the pin a compare output when the channel's select bit is set.
// - Masked pins take their level from the channel 7 data bit.
// - Channel 7 compare wins over channels 6 to 0 on a pin.
// - Overflow flag sets when counter wraps from maximum to zero.
//
// Design decision made here: register access over AXI4-Lite.
`include "tcoc_defines.svh"

module tcoc_timer
  import tcoc_pkg::*;
#(
  parameter int PRESCALE_DIV = 1,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic testMode,
  input wire logic waitMode,
  input wire logic freezeMode,
  input wire logic paOverflowEvent,
  input wire logic paEdgeEvent,
  output logic [7:0] timerPinOut,
  output logic [7:0] timerPinOe,
  output logic paClockTick
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic idxMapped(input logic [5:0] idx);
    idxMapped = (idx <= `TCOC_IDX_ACTH + 6'h01) || idx == `TCOC_IDX_FLG1 ||
                idx == `TCOC_IDX_FLG2 ||
                (idx >= `TCOC_IDX_TC_FIRST && idx <= `TCOC_IDX_TC_LAST) ||
                (idx >= `TCOC_IDX_PULSE_ACCUM_FLAG_REG && idx <= `TCOC_IDX_PACL);
  endfunction

  function automatic logic idxIsChan(input logic [5:0] idx, input logic [2:0] ch);
    idxIsChan = idx >= `TCOC_IDX_TC_FIRST && idx <= `TCOC_IDX_TC_LAST && idx[3:1] == ch;
  endfunction

  function automatic logic applyAction(input logic [1:0] act, input logic cur);
    case (act)
      ACT_TOGGLE: applyAction = ~cur;
      ACT_CLEAR: applyAction = 1'b0;
      ACT_SET: applyAction = 1'b1;
      default: applyAction = cur;
    endcase
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  tcoc_wrstate_type wrState_r;
  tcoc_ctrl_type ctrl_r;
  logic awHeld_r, wHeld_r, wStrb0_r;
  logic [5:0] wrIdx_r;
  logic [7:0] wrByte_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] select_r, mask7_r, data7_r, tov_r, chFlag_r, pinOut_r, pinOe_r;
  logic [15:0] actMode_r;
  logic [15:0] cnt_r;
  logic [15:0] tc_r [8];
  logic [7:0] preCnt_r;
  logic [5:0] pulse_accum_count_r;
  logic tof_r, pulse_accum_overflow_flag_r, pulse_accum_edge_flag_r, paTick_r;

  logic wrFire, wrEn, rdFire;
  logic [5:0] rdIdx;
  logic moduleActive, counting, tick, overflow;
  logic [15:0] cntInc;
  logic [7:0] hit, forceVec, chClr;
  logic c7Fire;

  assign rdIdx = araddr[7:2];
  assign wrFire = (wrState_r == WR_IDLE) && awHeld_r && wHeld_r;
  assign wrEn = wrFire && wStrb0_r;
  assign rdFire = arvalid && arready_r;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrState_r <= WR_IDLE;
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `TCOC_RESP_OKAY;
      wrIdx_r <= 6'h00;
      wrByte_r <= `TCOC_RST_BYTE;
      wStrb0_r <= 1'b0;
    end else begin
      case (wrState_r)
        WR_IDLE: begin
          if (awvalid && awready_r) begin
            wrIdx_r <= awaddr[7:2];
            awHeld_r <= 1'b1;
            awready_r <= 1'b0;
          end
          if (wvalid && wready_r) begin
            wrByte_r <= wdata[7:0];
            wStrb0_r <= wstrb[0];
            wHeld_r <= 1'b1;
            wready_r <= 1'b0;
          end
          if (wrFire) begin
            bvalid_r <= 1'b1;
            bresp_r <= idxMapped(wrIdx_r) ? `TCOC_RESP_OKAY : `TCOC_RESP_SLVERR;
            wrState_r <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (bready) begin
            bvalid_r <= 1'b0;
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            wrState_r <= WR_IDLE;
          end
        end
        default: wrState_r <= WR_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `TCOC_RESP_OKAY;
    end else if (rdFire) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rresp_r <= idxMapped(rdIdx) ? `TCOC_RESP_OKAY : `TCOC_RESP_SLVERR;
      if (rdIdx == `TCOC_IDX_SELECT) begin
        rdata_r <= {24'h000000, select_r};
      end else if (rdIdx == `TCOC_IDX_MASK7) begin
        rdata_r <= {24'h000000, mask7_r};
      end else if (rdIdx == `TCOC_IDX_DATA7) begin
        rdata_r <= {24'h000000, data7_r};
      end else if (rdIdx == `TCOC_IDX_CNTH) begin
        rdata_r <= {24'h000000, cnt_r[15:8]};
      end else if (rdIdx == `TCOC_IDX_CNTL) begin
        rdata_r <= {24'h000000, cnt_r[7:0]};
      end else if (rdIdx == `TCOC_IDX_SCR1) begin
        rdata_r <= {24'h000000, ctrl_r, 4'h0};
      end else if (rdIdx == `TCOC_IDX_TOV) begin
        rdata_r <= {24'h000000, tov_r};
      end else if (rdIdx == `TCOC_IDX_ACTH) begin
        rdata_r <= {24'h000000, actMode_r[15:8]};
      end else if (rdIdx == `TCOC_IDX_ACTL) begin
        rdata_r <= {24'h000000, actMode_r[7:0]};
      end else if (rdIdx == `TCOC_IDX_FLG1) begin
        rdata_r <= {24'h000000, chFlag_r};
      end else if (rdIdx == `TCOC_IDX_FLG2) begin
        rdata_r <= {24'h000000, tof_r, 7'h00};
      end else if (rdIdx >= `TCOC_IDX_TC_FIRST && rdIdx <= `TCOC_IDX_TC_LAST) begin
        rdata_r <= {24'h000000, rdIdx[0] ? tc_r[rdIdx[3:1]][7:0] : tc_r[rdIdx[3:1]][15:8]};
      end else if (rdIdx == `TCOC_IDX_PULSE_ACCUM_FLAG_REG) begin
        rdata_r <= {30'h00000000, pulse_accum_overflow_flag_r, pulse_accum_edge_flag_r};
      end else begin
        // Force register, accumulator count and holes read zero
        rdata_r <= 32'h0000_0000;
      end
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      select_r <= `TCOC_RST_BYTE;
      mask7_r <= `TCOC_RST_BYTE;
      data7_r <= `TCOC_RST_BYTE;
      ctrl_r <= '0;
      tov_r <= `TCOC_RST_BYTE;
      actMode_r <= `TCOC_RST_WORD;
    end else if (wrEn) begin
      if (wrIdx_r == `TCOC_IDX_SELECT) begin
        select_r <= wrByte_r;
      end else if (wrIdx_r == `TCOC_IDX_MASK7) begin
        mask7_r <= wrByte_r;
      end else if (wrIdx_r == `TCOC_IDX_DATA7) begin
        data7_r <= wrByte_r;
      end else if (wrIdx_r == `TCOC_IDX_SCR1) begin
        ctrl_r <= wrByte_r[`TCOC_BIT_TEN:`TCOC_BIT_FFCA];
      end else if (wrIdx_r == `TCOC_IDX_TOV) begin
        tov_r <= wrByte_r;
      end else if (wrIdx_r == `TCOC_IDX_ACTH) begin
        actMode_r[15:8] <= wrByte_r;
      end else if (wrIdx_r == `TCOC_IDX_ACTL) begin
        actMode_r[7:0] <= wrByte_r;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        tc_r[i] <= `TCOC_RST_WORD;
      end
    end else if (wrEn && wrIdx_r >= `TCOC_IDX_TC_FIRST && wrIdx_r <= `TCOC_IDX_TC_LAST) begin
      if (wrIdx_r[0]) begin
        tc_r[wrIdx_r[3:1]][7:0] <= wrByte_r;
      end else begin
        tc_r[wrIdx_r[3:1]][15:8] <= wrByte_r;
      end
    end
  end

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  // enable gate
  assign moduleActive = ctrl_r.enable && !(waitMode && ctrl_r.stopInWait);
  assign counting = moduleActive && !(freezeMode && ctrl_r.stopInFreeze);
  assign tick = counting && (preCnt_r == 8'(PRESCALE_DIV - 1));
  assign cntInc = cnt_r + 16'h0001;
  assign overflow = tick && (cnt_r == `TCOC_CNT_MAX);

  // Counter writes leave the prescaler alone, so the next period is uneven
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      preCnt_r <= 8'h00;
    end else if (counting) begin
      preCnt_r <= tick ? 8'h00 : preCnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= `TCOC_RST_WORD;
    end else if (wrEn && testMode && wrIdx_r == `TCOC_IDX_CNTH) begin
      cnt_r[15:8] <= wrByte_r;
    end else if (wrEn && testMode && wrIdx_r == `TCOC_IDX_CNTL) begin
      cnt_r[7:0] <= wrByte_r;
    end else if (tick) begin
      cnt_r <= cntInc;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_accum_count_r <= 6'h00;
      paTick_r <= 1'b0;
    end else begin
      paTick_r <= moduleActive && (pulse_accum_count_r == `TCOC_PA_DIV_LAST);
      if (moduleActive) begin
        pulse_accum_count_r <= pulse_accum_count_r + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // Compare events and flags
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      hit[i] = tick && select_r[i] && (cntInc == tc_r[i]);
      chClr[i] = (wrEn && wrIdx_r == `TCOC_IDX_FLG1 && wrByte_r[i]) ||
                 (ctrl_r.fastFlagClear && select_r[i] && wrFire &&
                  idxIsChan(wrIdx_r, 3'(i))) ||
                 (ctrl_r.fastFlagClear && !select_r[i] && rdFire &&
                  idxIsChan(rdIdx, 3'(i)));
    end
  end

  assign forceVec = (wrEn && wrIdx_r == `TCOC_IDX_FORCE) ? (wrByte_r & select_r) : 8'h00;
  assign c7Fire = hit[7] || forceVec[7];

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chFlag_r <= `TCOC_RST_BYTE;
    end else begin
      chFlag_r <= hit | (chFlag_r & ~chClr);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tof_r <= 1'b0;
    end else if (overflow) begin
      tof_r <= 1'b1;
    end else if ((wrEn && wrIdx_r == `TCOC_IDX_FLG2 && wrByte_r[`TCOC_BIT_TOF]) ||
                 (ctrl_r.fastFlagClear &&
                  ((wrFire && (wrIdx_r == `TCOC_IDX_CNTH || wrIdx_r == `TCOC_IDX_CNTL)) ||
                   (rdFire && (rdIdx == `TCOC_IDX_CNTH || rdIdx == `TCOC_IDX_CNTL))))) begin
      tof_r <= 1'b0;
    end
  end

  logic paClr, paOvfWr, paIfWr;
  assign paClr = ctrl_r.fastFlagClear &&
                 ((wrFire && (wrIdx_r == `TCOC_IDX_PACH || wrIdx_r == `TCOC_IDX_PACL)) ||
                  (rdFire && (rdIdx == `TCOC_IDX_PACH || rdIdx == `TCOC_IDX_PACL)));
  assign paOvfWr = wrEn && wrIdx_r == `TCOC_IDX_PULSE_ACCUM_FLAG_REG && wrByte_r[`TCOC_BIT_PULSE_ACCUM_OVERFLOW_FLAG];
  assign paIfWr = wrEn && wrIdx_r == `TCOC_IDX_PULSE_ACCUM_FLAG_REG && wrByte_r[`TCOC_BIT_PULSE_ACCUM_EDGE_FLAG];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_accum_overflow_flag_r <= 1'b0;
      pulse_accum_edge_flag_r <= 1'b0;
    end else begin
      pulse_accum_overflow_flag_r <= paOverflowEvent || (pulse_accum_overflow_flag_r && !(paClr || paOvfWr));
      pulse_accum_edge_flag_r <= paEdgeEvent || (pulse_accum_edge_flag_r && !(paClr || paIfWr));
    end
  end

  // ----------------------------------------
  // Pin actions
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinOut_r <= `TCOC_RST_BYTE;
      pinOe_r <= `TCOC_RST_BYTE;
    end else begin
      for (int b = 0; b < 8; b++) begin
        pinOe_r[b] <= select_r[b] && ((actMode_r[2*b+:2] != ACT_NONE) || mask7_r[b]);
        if (c7Fire && mask7_r[b]) begin
          pinOut_r[b] <= data7_r[b];
        end else if (overflow && tov_r[b] && select_r[b]) begin
          pinOut_r[b] <= ~pinOut_r[b];
        end else if (hit[b] || forceVec[b]) begin
          pinOut_r[b] <= applyAction(actMode_r[2*b+:2], pinOut_r[b]);
        end
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready = awready_r;
  assign wready = wready_r;
  assign bresp = bresp_r;
  assign bvalid = bvalid_r;
  assign arready = arready_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign rvalid = rvalid_r;
  assign timerPinOut = pinOut_r;
  assign timerPinOe = pinOe_r;
  assign paClockTick = paTick_r;

endmodule

// file: tcoc_timer_monitor.sv
// Checker for the timer core: bus handshakes, accumulator tick and pin timing.
// Assumes it is bound to tcoc_timer and sees only that module's ports.
`include "tcoc_defines.svh"

module tcoc_timer_monitor
  import tcoc_pkg::*;
#(
  parameter int PRESCALE_DIV = 1,
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic waitMode,
  input wire logic [7:0] timerPinOut,
  input wire logic [7:0] timerPinOe,
  input wire logic paClockTick
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------
  // Shadow control register and tick counters
  // ------
  // Shadow lags the design by a cycle, so the properties leave slack for it
  logic [ADDR_W-1:0] awQ_r;
  logic [7:0] wQ_r, scr_r, gap_r, runCnt_r, offCnt_r;
  logic bvPrev_r;
  logic paRun;

  assign paRun = scr_r[`TCOC_BIT_TEN] && !(scr_r[`TCOC_BIT_SWAI] && waitMode);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awQ_r <= '0;
      wQ_r <= 8'h00;
      scr_r <= 8'h00;
      bvPrev_r <= 1'h0;
    end else begin
      if (awvalid && awready) awQ_r <= awaddr;
      if (wvalid && wready) wQ_r <= wdata[7:0];
      if (bvalid && !bvPrev_r && bresp == `TCOC_RESP_OKAY && awQ_r[7:2] == `TCOC_IDX_SCR1)
        scr_r <= wQ_r;
      bvPrev_r <= bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gap_r <= 8'h00;
      runCnt_r <= 8'h00;
      offCnt_r <= 8'h00;
    end else begin
      gap_r <= paClockTick ? 8'h00 : gap_r + {7'h00, gap_r != 8'hFF};
      runCnt_r <= paRun ? runCnt_r + {7'h00, runCnt_r != 8'hFF} : 8'h00;
      offCnt_r <= paRun ? 8'h00 : offCnt_r + {7'h00, offCnt_r != 8'hFF};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tick_pulse; paClockTick |=> (!paClockTick)[*8]; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick too wide");
  property p_tick_gap; paClockTick |-> gap_r >= 8'h3F; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("ticks too close");
  property p_tick_off; !paRun && offCnt_r > 8'h02 |-> !paClockTick; endproperty
  a_tick_off: assert property (p_tick_off) else $error("tick while stopped");
  property p_tick_run; runCnt_r > 8'h46 |-> gap_r < 8'h40; endproperty
  a_tick_run: assert property (p_tick_run) else $error("tick missing");
  property p_oe_cause; $changed(timerPinOe) |-> bvalid || $past(bvalid) || $past(bvalid, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("enable moved alone");
  // A write lands on the edge where bvalid rises, so that edge may move a pin
  property p_pin_idle; !scr_r[7] && !bvalid && !$past(bvalid) |=>
    $stable(timerPinOut) || $rose(bvalid);
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("pin moved while off");
  property p_rd_answer; arvalid && arready |=> rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  property p_rd_byte; rvalid |-> rdata[31:8] == 24'h000000; endproperty
  a_rd_byte: assert property (p_rd_byte) else $error("read upper bits set");
  property p_wr_busy; bvalid |-> !awready && !wready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
  property p_b_done; bvalid && bready |=> !bvalid && awready && wready; endproperty
  a_b_done: assert property (p_b_done) else $error("write not released");
endmodule

bind tcoc_timer tcoc_timer_monitor #(.PRESCALE_DIV(PRESCALE_DIV), .ADDR_W(ADDR_W))
  tcoc_timer_monitor_inst (
  .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .waitMode(waitMode), .timerPinOut(timerPinOut),
  .timerPinOe(timerPinOe), .paClockTick(paClockTick)
);

// file: timer_counter_output_compare_tb.sv
// Self-checking bench for the timer core, driven through AXI4-Lite tasks.
// Assumes the core, its package, checker and port model are compiled first.
`include "tcoc_defines.svh"

module timer_counter_output_compare_tb
  import tcoc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic testMode = 1'h0, waitMode = 1'h0, freezeMode = 1'h0, pulse_accum_overflow_flag = 1'h0, paEdge = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, lastResp;
  logic [31:0] rdata;
  logic [7:0] pinOut, pinOe, pinLevel, v1, v2;
  logic [7:0] mScr [5] = '{8'hC0, 8'h80, 8'hA0, 8'h80, 8'h00};
  logic [1:0] mWf [5] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0};
  logic [7:0] mStep [5] = '{8'h00, 8'h03, 8'h00, 8'h03, 8'h00};
  int n_errors = 0, checked = 0, cycles = 0;

  tcoc_timer #(.PRESCALE_DIV(1), .ADDR_W(8)) tcoc_timer_inst (
    .clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .testMode(testMode), .waitMode(waitMode), .freezeMode(freezeMode),
    .paOverflowEvent(pulse_accum_overflow_flag), .paEdgeEvent(paEdge), .timerPinOut(pinOut),
    .timerPinOe(pinOe), .paClockTick()
  );
  tcoc_port_model tcoc_port_model_inst (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));

  // ------
  // Clock, timeout and bus tasks
  // ------
  initial forever #25 clk = ~clk;

  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Whole run is under 2000 cycles; the ceiling leaves ample slack
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // Handshakes are sampled at the falling edge, where nothing moves
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic a, w, b;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(negedge clk);
      a = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      r = bresp;
      @(posedge clk);
      if (a) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
      if (b) break;
    end
    bready <= 1'h0;
    lastResp = r;
  endtask

  task automatic rd(input logic [5:0] idx, output logic [7:0] d);
    logic a, h;
    logic [1:0] r;
    @(posedge clk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(negedge clk);
      a = arvalid && arready;
      h = rvalid && rready;
      d = rdata[7:0];
      r = rresp;
      @(posedge clk);
      if (a) arvalid <= 1'h0;
      if (h) break;
    end
    rready <= 1'h0;
    lastResp = r;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    rd(`TCOC_IDX_SCR1, v1);
    chk("ctrl reset", 8'h00, v1);
    wr(`TCOC_IDX_CNTH, 8'h12);
    rd(`TCOC_IDX_CNTH, v1);
    chk("cnt locked", 8'h00, v1);
    testMode <= 1'h1;
    wr(`TCOC_IDX_CNTH, 8'hFF);
    wr(`TCOC_IDX_CNTL, 8'hF0);
    rd(`TCOC_IDX_CNTL, v1); // counter held still, so byte reads cannot tear
    chk("cnt low", 8'hF0, v1);
    wr(`TCOC_IDX_SELECT, 8'h01);
    wr(`TCOC_IDX_TC_FIRST, 8'h80);
    wr(`TCOC_IDX_TOV, 8'h01);
    wr(`TCOC_IDX_ACTL, 8'h01);
    @(negedge clk);
    chk("drive ch0", 8'h01, pinOe);
    wr(`TCOC_IDX_SCR1, 8'h80);
    // Long enough for the checker to see a full accumulator tick period
    repeat (80) @(posedge clk);
    @(negedge clk);
    chk("ovf toggle", 8'h01, pinLevel);
    rd(`TCOC_IDX_FLG2, v1);
    chk("ovf flag", 8'h80, v1);
    wr(`TCOC_IDX_SCR1, 8'h90);
    rd(`TCOC_IDX_CNTH, v1);
    rd(`TCOC_IDX_FLG2, v1);
    chk("ovf fast clr", 8'h00, v1);
    for (int i = 0; i < 5; i++) begin
      wr(`TCOC_IDX_SCR1, mScr[i]);
      waitMode <= mWf[i][1];
      freezeMode <= mWf[i][0];
      rd(`TCOC_IDX_CNTL, v1);
      rd(`TCOC_IDX_CNTL, v2);
      chk("cnt step", mStep[i], v2 - v1);
    end
    pulse_accum_overflow_flag <= 1'h1;
    paEdge <= 1'h1;
    @(posedge clk);
    pulse_accum_overflow_flag <= 1'h0;
    paEdge <= 1'h0;
    rd(`TCOC_IDX_PULSE_ACCUM_FLAG_REG, v1);
    chk("acc flags", 8'h03, v1);
    wr(`TCOC_IDX_SCR1, 8'h10);
    rd(`TCOC_IDX_PACL, v1);
    rd(`TCOC_IDX_PULSE_ACCUM_FLAG_REG, v1);
    chk("acc fast clr", 8'h00, v1);
    wr(6'h30, 8'h55);
    chk("bad index", 8'h02, {6'h00, lastResp});
    rd(6'h30, v1);
    chk("bad rd index", 8'h02, {6'h00, lastResp});
    wr(`TCOC_IDX_SELECT, 8'h8E);
    wr(`TCOC_IDX_MASK7, 8'h00);
    for (int c = 3; c >= 0; c--) begin
      wr(`TCOC_IDX_ACTL, 8'(c << 2));
      wr(`TCOC_IDX_FORCE, 8'h02);
      @(negedge clk);
      chk("pin1 level", 8'((c & 1) << 1), pinLevel);
      chk("pin1 drive", (c != 0) ? 8'h02 : 8'h00, pinOe);
    end
    wr(`TCOC_IDX_ACTL, 8'h20);
    wr(`TCOC_IDX_MASK7, 8'h0C); // channel 7 select one, action zero, mask bit 7 clear
    wr(`TCOC_IDX_DATA7, 8'h04);
    wr(`TCOC_IDX_FORCE, 8'h84);
    @(negedge clk);
    chk("ch7 wins", 8'h04, pinLevel);
    chk("ch7 drive", 8'h0C, pinOe);
    wr(`TCOC_IDX_CNTH, 8'hFF);
    wr(`TCOC_IDX_CNTL, 8'hFE);
    wr(`TCOC_IDX_SCR1, 8'h90);
    repeat (8) @(posedge clk);
    rd(`TCOC_IDX_FLG1, v1);
    chk("cmp flags", 8'h8E, v1);
    wr(6'h12, 8'h00);
    rd(`TCOC_IDX_FLG1, v1);
    chk("cmp fast clr", 8'h8C, v1);
    wr(`TCOC_IDX_SELECT, 8'h0E);
    rd(6'h1E, v1);
    rd(`TCOC_IDX_FLG1, v1);
    chk("cap fast clr", 8'h0C, v1);
    report_and_stop();
  end
endmodule
